/* File: rtl/sstx_regs.svh */
// Register offsets, field positions and reset values of the transmit block.
// Included by the design; definitions only.
`ifndef SSTX_REGS_SVH
`define SSTX_REGS_SVH
`define SSTX_OFF_CTRL 8'h00
`define SSTX_OFF_TCMR 8'h04
`define SSTX_OFF_TFMR 8'h08
`define SSTX_OFF_RHR 8'h0C
`define SSTX_OFF_THR 8'h10
`define SSTX_OFF_TSHR 8'h14
`define SSTX_OFF_STAT 8'h18
`define SSTX_OFF_RXIN 8'h1C
`define SSTX_CKS_LSB 0
`define SSTX_CKO_LSB 2
`define SSTX_CKI_BIT 5
`define SSTX_CKG_LSB 6
`define SSTX_START_LSB 8
`define SSTX_START_DELAY_LSB 16
`define SSTX_PERIOD_LSB 24
`define SSTX_WORD_BIT_COUNT_LSB 0
`define SSTX_IDLE_DATA_LEVEL_BIT 5
`define SSTX_HIGH_BIT_FIRST_BIT 7
`define SSTX_WORDS_PER_FRAME_LSB 8
`define SSTX_SYNC_PULSE_LENGTH_LSB 16
`define SSTX_SYNC_OUTPUT_SHAPE_LSB 20
`define SSTX_SYNC_DATA_ENABLE_BIT 23
`define SSTX_SYNC_EVENT_EDGE_BIT 24
`define SSTX_TCMR_RST 32'h00000000
`define SSTX_TFMR_RST 32'h00000000
`define SSTX_TCMR_MASK 32'hFFFF0FFF
`define SSTX_TFMR_MASK 32'h01FF0FBF
`endif

/* File: rtl/sstx_pkg.sv */
// Types shared by the transmit clock and frame block.
// Assumes the register header sits beside it.
package sstx_pkg;
    typedef enum logic [1:0] {
        SSTX_IDLE,
        SSTX_DELAY,
        SSTX_DATA
    } sstx_phase_e;

    // Pin group: output and output enable per pin
    typedef struct packed {
        logic tk_o;
        logic tk_oe;
        logic tf_o;
        logic tf_oe;
        logic td_o;
        logic td_oe;
    } sstx_pins_s;

    typedef struct packed {
        logic [31:0] tcmr;
        logic [31:0] tfmr;
        logic [31:0] thr;
        logic [15:0] tshr;
        logic [31:0] rhr;
        logic thr_full;
        logic tx_en;
        logic sync_flag;
        logic [2:0] sync_tf;
        logic [2:0] sync_tk;
        logic [2:0] sync_rk;
        logic tk_prev;
        logic tf_prev;
        logic tf_smp;
        logic [7:0] div_cnt;
        logic div_clk;
        sstx_phase_e phase;
        logic [7:0] dly_cnt;
        logic [4:0] fs_cnt;
        logic [4:0] bit_cnt;
        logic [3:0] word_cnt;
        logic [31:0] shreg;
        logic [15:0] sync_sh;
        logic [8:0] per_cnt;
        logic fs_out;
        logic fs_toggle;
        logic td_q;
        logic fs_prev;
        logic hwrite;
        logic hsel;
        logic [7:0] haddr;
    } sstx_state_s;
endpackage

/* File: rtl/sstx_core.sv */
// Transmit clock selection, start control, frame sync and data shifter of a
// synchronous serial controller, with an AHB-Lite register slave.
// Assumes pins arrive asynchronous and are resynchronised to ref_clk.
// Overview of operation
// - Clock source 0 divided clock, 1 receive clock pin, 2 transmit pin.
// - Clock out mode 0 input, 1 continuous, 2 only during transfer.
// - Uninverted: outputs change falling, frame sampled rising; invert swaps.
// - Inversion acts inside only, never on the driven clock pin.
// - Gating 0 continuous, 1 only frame pin low, 2 only high.
// - Start 0 on holding write when enabled; 1 starts with reception.
// - Start 2..7 frame low, high, fall, rise, change, any edge.
// - Nonzero start delay inserts that many clocks before first bit.
// - Start delay applies also when starting with receiver.
// - Period zero none; N gives frame sync every 2*(N+1) clocks.
// - Each word holds word length field plus one bits.
// - DMA size byte up to 7, half to 15, else word.
// - Idle data level drives data pin outside transmission.
// - Open-drain data pin enabled only while data output is one.
// - Bit order 0 low bit first, 1 high bit first.
// - Each start sends up to words per frame field plus one words; ends early if holding register is empty.
// - Sync pulse lasts length plus one clocks; also sync data bits.
// - Sync shape 0 input, 1..5 neg, pos, low, high, toggle.
// - During sync, data pin idle level or shifts sync holding value.
// - Sync edge bit 0 rising, 1 falling raises sync event.
// - Transmit and receive words right aligned in 32-bit register.
// - Sync flag set on event, held until status is read.
//
// Design decisions made here: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "sstx_regs.svh"
module sstx_core
    import sstx_pkg::*;
#(
    parameter int DIV_W = 8
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic tx_clock_pin_i,
    input wire logic tx_frame_pin_i,
    input wire logic rx_clock_pin_i,
    input wire logic rx_start,
    input wire logic od_mode,
    input wire logic [DIV_W-1:0] div_half,
    output sstx_pins_s pins,
    output logic [1:0] dma_size,
    output logic tx_ready
);
    sstx_state_s s_q, s_d;
    logic [1:0] tx_clock_source, tx_clock_out_mode, tx_clock_gating;
    logic tx_clock_invert, idle_data_level, high_bit_first, sync_data_enable, sync_event_edge;
    logic [3:0] start_sel, words_per_frame, sync_pulse_length;
    logic [7:0] start_delay, period;
    logic [4:0] word_bit_count;
    logic [2:0] sync_output_shape;
    logic src_clk, tf_s, gate_ok, clk_int, clk_prev_int;
    logic shift_edge, samp_edge, tf_rise, tf_fall, start_ev, busy;
    logic fs_rise, fs_fall;

    // Field extraction
    assign tx_clock_source = s_q.tcmr[`SSTX_CKS_LSB +: 2];
    assign tx_clock_out_mode = s_q.tcmr[`SSTX_CKO_LSB +: 2];
    assign tx_clock_invert = s_q.tcmr[`SSTX_CKI_BIT];
    assign tx_clock_gating = s_q.tcmr[`SSTX_CKG_LSB +: 2];
    assign start_sel = s_q.tcmr[`SSTX_START_LSB +: 4];
    assign start_delay = s_q.tcmr[`SSTX_START_DELAY_LSB +: 8];
    assign period = s_q.tcmr[`SSTX_PERIOD_LSB +: 8];
    assign word_bit_count = s_q.tfmr[`SSTX_WORD_BIT_COUNT_LSB +: 5];
    assign idle_data_level = s_q.tfmr[`SSTX_IDLE_DATA_LEVEL_BIT];
    assign high_bit_first = s_q.tfmr[`SSTX_HIGH_BIT_FIRST_BIT];
    assign words_per_frame = s_q.tfmr[`SSTX_WORDS_PER_FRAME_LSB +: 4];
    assign sync_pulse_length = s_q.tfmr[`SSTX_SYNC_PULSE_LENGTH_LSB +: 4];
    assign sync_output_shape = s_q.tfmr[`SSTX_SYNC_OUTPUT_SHAPE_LSB +: 3];
    assign sync_data_enable = s_q.tfmr[`SSTX_SYNC_DATA_ENABLE_BIT];
    assign sync_event_edge = s_q.tfmr[`SSTX_SYNC_EVENT_EDGE_BIT];
    assign tf_s = s_q.sync_tf[1];
    assign busy = (s_q.phase != SSTX_IDLE);

    // Clock source; reserved code gives a stopped clock
    always_comb begin
        case (tx_clock_source)
            2'h0: src_clk = s_q.div_clk;
            2'h1: src_clk = s_q.sync_rk[1];
            2'h2: src_clk = s_q.sync_tk[1];
            default: src_clk = 1'b0;
        endcase
    end

    // Gating; frame level is the synchronised pin
    always_comb begin
        case (tx_clock_gating)
            2'h0: gate_ok = 1'b1;
            2'h1: gate_ok = ~tf_s;
            2'h2: gate_ok = tf_s;
            default: gate_ok = 1'b0;
        endcase
    end

    // Inverted copy is internal only; the pin gets src_clk
    assign clk_int = (src_clk ^ tx_clock_invert) & gate_ok;
    assign clk_prev_int = (s_q.tk_prev ^ tx_clock_invert) & gate_ok;
    // Uninverted: shift on falling, sample on rising
    assign shift_edge = clk_prev_int & ~clk_int;
    assign samp_edge = ~clk_prev_int & clk_int;
    // Edges come from the last two sampled frame levels; they stay visible
    // until the next sample edge, so the shift-edge sequencer can see them
    assign tf_rise = s_q.tf_smp & ~s_q.tf_prev;
    assign tf_fall = ~s_q.tf_smp & s_q.tf_prev;

    // Start event selection
    always_comb begin
        case (start_sel)
            4'h0: start_ev = s_q.thr_full & s_q.tx_en;
            4'h1: start_ev = rx_start & s_q.tx_en;
            4'h2: start_ev = ~s_q.tf_smp;
            4'h3: start_ev = s_q.tf_smp;
            4'h4: start_ev = tf_fall;
            4'h5: start_ev = tf_rise;
            4'h6: start_ev = tf_fall | tf_rise;
            4'h7: start_ev = tf_fall | tf_rise;
            default: start_ev = 1'b0;
        endcase
    end

    assign fs_rise = s_q.fs_out & ~s_q.fs_prev;
    assign fs_fall = ~s_q.fs_out & s_q.fs_prev;

    // Next state: bus slave, synchronisers, divider and transmit sequencer
    always_comb begin
        s_d = s_q;
        s_d.sync_tf = {s_q.sync_tf[1:0], tx_frame_pin_i};
        s_d.sync_tk = {s_q.sync_tk[1:0], tx_clock_pin_i};
        s_d.sync_rk = {s_q.sync_rk[1:0], rx_clock_pin_i};
        s_d.tk_prev = src_clk;
        s_d.fs_prev = s_q.fs_out;
        if (samp_edge) begin
            s_d.tf_prev = s_q.tf_smp;
            s_d.tf_smp = tf_s;
        end
        // Divided clock toggles every div_half+1 reference cycles
        if (s_q.div_cnt >= 8'(div_half)) begin
            s_d.div_cnt = 8'h00;
            s_d.div_clk = ~s_q.div_clk;
        end else begin
            s_d.div_cnt = s_q.div_cnt + 8'h01;
        end
        // Address phase of a transfer captured for its data phase
        s_d.hsel = hsel & hready & htrans[1];
        s_d.hwrite = hwrite;
        s_d.haddr = haddr[7:0];
        if (s_q.hsel && s_q.hwrite) begin
            case (s_q.haddr)
                `SSTX_OFF_CTRL: s_d.tx_en = hwdata[0];
                `SSTX_OFF_TCMR: s_d.tcmr = hwdata & `SSTX_TCMR_MASK;
                `SSTX_OFF_TFMR: s_d.tfmr = hwdata & `SSTX_TFMR_MASK;
                `SSTX_OFF_THR: begin
                    s_d.thr = hwdata;
                    s_d.thr_full = 1'b1;
                end
                `SSTX_OFF_TSHR: s_d.tshr = hwdata[15:0];
                `SSTX_OFF_RXIN: s_d.rhr = hwdata;
                default: ;
            endcase
        end
        // Status read clears the sync flag; a new event below wins
        if (s_q.hsel && !s_q.hwrite && s_q.haddr == `SSTX_OFF_STAT) begin
            s_d.sync_flag = 1'b0;
        end
        if ((sync_event_edge == 1'b0 && fs_rise) || (sync_event_edge == 1'b1 && fs_fall)) begin
            s_d.sync_flag = 1'b1;
        end
        // Periodic frame-sync counter, in units of clock periods
        if (period == 8'h00) begin
            s_d.per_cnt = 9'h000;
        end else if (shift_edge) begin
            if (s_q.per_cnt >= {period, 1'b1}) begin
                s_d.per_cnt = 9'h000;
            end else begin
                s_d.per_cnt = s_q.per_cnt + 9'h001;
            end
        end
        if (shift_edge) begin
            if (s_q.fs_cnt != 5'h00) begin
                s_d.fs_cnt = s_q.fs_cnt - 5'h01;
                s_d.sync_sh = {1'b0, s_q.sync_sh[15:1]};
            end
            if (period != 8'h00 && s_q.per_cnt == 9'h000) begin
                s_d.fs_cnt = {1'b0, sync_pulse_length} + 5'h01;
                s_d.sync_sh = s_q.tshr;
            end
            case (s_q.phase)
                SSTX_IDLE: begin
                    if (start_ev && s_q.thr_full) begin
                        s_d.fs_cnt = {1'b0, sync_pulse_length} + 5'h01;
                        s_d.sync_sh = s_q.tshr;
                        s_d.fs_toggle = ~s_q.fs_toggle;
                        s_d.word_cnt = words_per_frame;
                        s_d.dly_cnt = start_delay;
                        s_d.phase = (start_delay == 8'h00) ? SSTX_DATA : SSTX_DELAY;
                        s_d.shreg = s_q.thr;
                        s_d.thr_full = 1'b0;
                        s_d.bit_cnt = word_bit_count;
                    end
                end
                SSTX_DELAY: begin
                    s_d.dly_cnt = s_q.dly_cnt - 8'h01;
                    if (s_q.dly_cnt == 8'h01) begin
                        s_d.phase = SSTX_DATA;
                    end
                end
                SSTX_DATA: begin
                    s_d.shreg = high_bit_first ? {s_q.shreg[30:0], 1'b0}
                                     : {1'b0, s_q.shreg[31:1]};
                    s_d.bit_cnt = s_q.bit_cnt - 5'h01;
                    if (s_q.bit_cnt == 5'h00) begin
                        if (s_q.word_cnt != 4'h0 && s_q.thr_full) begin
                            s_d.word_cnt = s_q.word_cnt - 4'h1;
                            s_d.shreg = s_q.thr;
                            s_d.thr_full = 1'b0;
                            s_d.bit_cnt = word_bit_count;
                        end else begin
                            s_d.phase = SSTX_IDLE;
                        end
                    end
                end
                default: s_d.phase = SSTX_IDLE;
            endcase
            // Data pin value; sync data until data phase takes over
            if (s_d.phase == SSTX_DATA) begin
                s_d.td_q = high_bit_first ? s_d.shreg[word_bit_count] : s_d.shreg[0];
            end else if (s_d.fs_cnt != 5'h00 && sync_data_enable) begin
                s_d.td_q = s_d.sync_sh[0];
            end else begin
                s_d.td_q = idle_data_level;
            end
            // Frame-sync waveform
            case (sync_output_shape)
                3'h1: s_d.fs_out = ~(s_d.fs_cnt != 5'h00);
                3'h2: s_d.fs_out = (s_d.fs_cnt != 5'h00);
                3'h3: s_d.fs_out = ~(s_d.phase == SSTX_DATA);
                3'h4: s_d.fs_out = (s_d.phase == SSTX_DATA);
                3'h5: s_d.fs_out = s_d.fs_toggle;
                default: s_d.fs_out = 1'b0;
            endcase
        end
    end

    // State register; reset takes constants only
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '0;
            s_q.tcmr <= `SSTX_TCMR_RST;
            s_q.tfmr <= `SSTX_TFMR_RST;
            s_q.phase <= SSTX_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // Read mux; unmapped addresses read zero, response always OKAY
    always_comb begin
        case (s_q.haddr)
            `SSTX_OFF_CTRL: hrdata = {31'h0, s_q.tx_en};
            `SSTX_OFF_TCMR: hrdata = s_q.tcmr;
            `SSTX_OFF_TFMR: hrdata = s_q.tfmr;
            `SSTX_OFF_RHR: hrdata = s_q.rhr;
            `SSTX_OFF_TSHR: hrdata = {16'h0, s_q.tshr};
            `SSTX_OFF_STAT: hrdata = {21'h0, s_q.sync_flag, 8'h0, busy,
                                      ~s_q.thr_full};
            default: hrdata = 32'h0;
        endcase
        if (!s_q.hsel || s_q.hwrite) begin
            hrdata = 32'h0;
        end
    end
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign tx_ready = ~s_q.thr_full;
    assign dma_size = (word_bit_count <= 5'd7) ? 2'd0 :
                      (word_bit_count <= 5'd15) ? 2'd1 : 2'd2;

    // Pin drive
    always_comb begin
        pins.tk_o = src_clk;
        pins.tk_oe = (tx_clock_out_mode == 2'h1) | ((tx_clock_out_mode == 2'h2) & busy);
        pins.tf_o = s_q.fs_out;
        pins.tf_oe = (sync_output_shape >= 3'h1) && (sync_output_shape <= 3'h5);
        pins.td_o = s_q.td_q;
        pins.td_oe = od_mode ? s_q.td_q : 1'b1;
    end
endmodule // sstx_core

/* File: tb/sstx_core_assertions.sv */
// Assertions on the bus and pin ports of the transmit block.
// Assumes it is bound to sstx_core and sees its ports only.
`timescale 1ns/1ps
module sstx_core_assertions
    import sstx_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic od_mode,
    input wire sstx_pins_s pins,
    input wire logic [1:0] dma_size
);
    logic dph_q, wr_q;
    logic [7:0] adr_q;
    logic [31:0] tcmr_q, tfmr_q;
    logic [2:0] tx_clock_out_mode, sync_output_shape;
    logic [1:0] dma_exp;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    // Shadow the mode registers; pin checks need the programmed codes
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            dph_q <= 1'b0;
            wr_q <= 1'b0;
            adr_q <= 8'h00;
            tcmr_q <= 32'h0;
            tfmr_q <= 32'h0;
        end else begin
            dph_q <= hsel && hready && htrans[1];
            wr_q <= hwrite;
            adr_q <= haddr[7:0];
            if (dph_q && wr_q && adr_q == 8'h04) begin
                tcmr_q <= hwdata;
            end
            if (dph_q && wr_q && adr_q == 8'h08) begin
                tfmr_q <= hwdata;
            end
        end
    end
    // Field views of the shadow copies
    assign tx_clock_out_mode = tcmr_q[4:2];
    assign sync_output_shape = tfmr_q[22:20];
    assign dma_exp = tfmr_q[4:0] < 5'h08 ? 2'h0 : tfmr_q[4] ? 2'h2 : 2'h1;
    chk_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus not ready or not okay");
    chk_dma_width: assert property (dma_size == dma_exp)
        else $error("dma size does not follow word length");
    chk_rdata_idle: assert property (!dph_q |-> hrdata == 32'h0)
        else $error("read data outside a data phase");
    chk_od_enable: assert property (
        od_mode && $past(od_mode) |-> pins.td_oe == pins.td_o)
        else $error("open-drain enable differs from data");
    chk_clk_off: assert property (
        (tx_clock_out_mode == 3'h0 || tx_clock_out_mode > 3'h2) [*2] |-> !pins.tk_oe)
        else $error("clock pin driven while output is off");
    chk_clk_on: assert property (
        (tx_clock_out_mode == 3'h1) [*2] |-> pins.tk_oe)
        else $error("continuous clock not driven");
    chk_frame_off: assert property (
        (sync_output_shape == 3'h0 || sync_output_shape > 3'h5) [*2] |-> !pins.tf_oe)
        else $error("frame pin driven while output is off");
    chk_frame_on: assert property (
        (sync_output_shape inside {[3'h1:3'h5]}) [*2] |-> pins.tf_oe)
        else $error("frame pin not driven in an output shape");
    cover property (dph_q && !wr_q);
    cover property ($rose(pins.tk_oe));
    cover property ($rose(pins.tf_oe));
endmodule // sstx_core_assertions
bind sstx_core sstx_core_assertions sstx_core_assertions_i (
    .ref_clk(ref_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .od_mode(od_mode), .pins(pins), .dma_size(dma_size)
);

/* File: tb/sstx_codec_model.sv */
// Far-side codec: drives the frame pin, owns a bit clock, captures data.
// Assumes data is taken on the rising clock pin edge while it is driven.
`timescale 1ns/1ps
module sstx_codec_model (
    input wire logic tk,
    input wire logic tk_oe,
    input wire logic td,
    input wire logic clr,
    input wire logic run,
    input wire logic frame_req,
    output logic tf,
    output logic ext_clk,
    output logic [7:0] word,
    output logic [5:0] cnt
);
    // Frame level as the peripheral drives it
    assign tf = frame_req;
    initial ext_clk = 1'b0;
    // Own bit clock stands still while run is low
    always begin
        #400;
        if (run) begin
            ext_clk = ~ext_clk;
        end
    end
    // Only edges of a driven clock count; a floating pin carries no bits
    always @(posedge tk or posedge clr) begin
        if (clr) begin
            word <= 8'h00;
            cnt <= 6'h00;
        end else if (tk_oe) begin
            word <= {word[6:0], td};
            cnt <= cnt + 6'h01;
        end
    end
endmodule // sstx_codec_model

/* File: tb/sync_serial_tx_clock_frame_bench.sv */
// Self-checking bench of the transmit clock and frame block.
// Assumes the checker binds itself and the codec model is compiled.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin samples_checked++; \
    if ((got) !== (ex)) begin error_cnt++; \
    $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module sync_serial_tx_clock_frame_bench import sstx_pkg::*;;
    logic ref_clk, hsel = 1'b0, hwrite = 1'b0, reset_n = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0] htrans = 2'h0, dma_size;
    logic od_mode = 1'b0, clr = 1'b1, run = 1'b0, frame_req = 1'b0;
    logic hreadyout, hresp, tf_far, ext_clk, tk_w, tf_w, td_w, tx_ready;
    logic [7:0] word;
    logic [5:0] cnt;
    sstx_pins_s pins;
    int error_cnt = 0;
    int samples_checked = 0;
    // Pins resolve from the block's enable; data line has a pull-up
    assign tk_w = pins.tk_oe ? pins.tk_o : ext_clk;
    assign tf_w = pins.tf_oe ? pins.tf_o : tf_far;
    assign td_w = pins.td_oe ? pins.td_o : 1'b1;
    sstx_core #(.DIV_W(8)) sstx_core_i (
        .ref_clk(ref_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .tx_clock_pin_i(tk_w), .tx_frame_pin_i(tf_w),
        .rx_clock_pin_i(ext_clk), .rx_start(1'b0), .od_mode(od_mode),
        .div_half(8'h07), .pins(pins), .dma_size(dma_size),
        .tx_ready(tx_ready));
    sstx_codec_model sstx_codec_model_i (
        .tk(pins.tk_o), .tk_oe(pins.tk_oe), .td(td_w), .clr(clr),
        .run(run), .frame_req(frame_req), .tf(tf_far),
        .ext_clk(ext_clk), .word(word), .cnt(cnt));
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    task automatic bus_edge();
        int n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
    endtask
    // One single word transfer; read data is taken at the closing edge
    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        bus_edge();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        bus_edge();
        rd = hrdata;
    endtask
    // Bounded wait for the codec bit count, then let the line settle
    task automatic send(input logic [7:0] v);
        int k = 0;
        clr <= 1'b1;
        @(posedge ref_clk);
        clr <= 1'b0;
        ahb(1'b1, 8'h10, {24'h0, v});
        while (cnt !== 6'h08 && k < 3000) begin
            @(posedge ref_clk);
            k++;
        end
        repeat (200) @(posedge ref_clk);
    endtask
    task automatic t_regs();
        ahb(1'b0, 8'h04, 32'h0);
        `CHK("tcmr_rst", 32'h0, rd)
        ahb(1'b1, 8'h04, 32'hFFFFFFFF);
        ahb(1'b0, 8'h04, 32'h0);
        `CHK("tcmr_rw", 32'hFFFF0FFF, rd)
        ahb(1'b1, 8'h08, 32'hFFFFFFFF);
        ahb(1'b0, 8'h08, 32'h0);
        `CHK("tfmr_rw", 32'h01FF0FBF, rd)
        `CHK("dma_max", 2'h2, dma_size)
        ahb(1'b1, 8'h0C, 32'h12345678);
        ahb(1'b1, 8'h1C, 32'h000000A5);
        ahb(1'b0, 8'h0C, 32'h0);
        `CHK("rhr", 32'h000000A5, rd)
        ahb(1'b0, 8'h40, 32'h0);
        `CHK("unmapped", 32'h0, rd)
        ahb(1'b1, 8'h04, 32'h00000004);
    endtask
    task automatic t_dma();
        logic [4:0] len [4] = '{5'h07, 5'h08, 5'h0F, 5'h10};
        logic [1:0] sz [4] = '{2'h0, 2'h1, 2'h1, 2'h2};
        for (int i = 0; i < 4; i++) begin
            ahb(1'b1, 8'h08, {27'h0, len[i]});
            @(posedge ref_clk);
            `CHK("dma", sz[i], dma_size)
        end
    endtask
    task automatic t_idle(input logic lvl);
        od_mode <= 1'b1;
        ahb(1'b1, 8'h08, {26'h0, lvl, 5'h07});
        // The data pin only follows at a shift edge of the slow bit clock
        repeat (40) @(posedge ref_clk);
        `CHK("idle", lvl, pins.td_o)
        `CHK("od_oe", lvl, pins.td_oe)
        od_mode <= 1'b0;
    endtask
    task automatic t_word(input logic high_bit_first, input logic [1:0] tx_clock_source,
                          input logic [7:0] v);
        logic [7:0] ex;
        ex = {<<{v}};
        if (high_bit_first) begin
            ex = v;
        end
        run <= (tx_clock_source == 2'h1);
        ahb(1'b1, 8'h08, {24'h0, high_bit_first, 7'h07});
        ahb(1'b1, 8'h04, {30'h2, tx_clock_source});
        send(v);
        `CHK("bits", 6'h08, cnt)
        `CHK("word", ex, word)
        `CHK("ready", 1'b1, tx_ready)
        run <= 1'b0;
    endtask
    task automatic t_sync();
        ahb(1'b1, 8'h08, 32'h00230007);
        ahb(1'b1, 8'h04, 32'h00040008);
        ahb(1'b0, 8'h18, 32'h0);
        send(8'hC3);
        ahb(1'b0, 8'h18, 32'h0);
        `CHK("sync_set", 1'b1, rd[10])
        ahb(1'b0, 8'h18, 32'h0);
        `CHK("sync_clr", 1'b0, rd[10])
    endtask
    task automatic t_frame();
        ahb(1'b1, 8'h08, 32'h00000007);
        ahb(1'b1, 8'h04, 32'h00000808);
        ahb(1'b1, 8'h10, 32'h0000001E);
        frame_req <= 1'b1;
        repeat (100) @(posedge ref_clk);
        frame_req <= 1'b0;
        repeat (100) @(posedge ref_clk);
        `CHK("no_start", 1'b0, tx_ready)
        ahb(1'b1, 8'h04, 32'h00000508);
        repeat (100) @(posedge ref_clk);
        `CHK("wait_edge", 1'b0, tx_ready)
        frame_req <= 1'b1;
        send(8'h1E);
        `CHK("edge_word", 8'h78, word)
        frame_req <= 1'b0;
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Main sequence after four reset cycles
    initial begin
        repeat (4) @(posedge ref_clk);
        reset_n <= 1'b1;
        clr <= 1'b0;
        t_regs();
        t_dma();
        t_idle(1'b1);
        t_idle(1'b0);
        ahb(1'b1, 8'h00, 32'h00000001);
        t_word(1'b0, 2'h0, 8'h4B);
        t_word(1'b1, 2'h0, 8'h4B);
        t_word(1'b0, 2'h1, 8'h3A);
        t_sync();
        t_frame();
        final_report();
    end
    // Watchdog well beyond the expected run length
    initial begin
        repeat (60000) @(posedge ref_clk);
        error_cnt++;
        final_report();
    end
endmodule // sync_serial_tx_clock_frame_bench
